// *** rtl/tapir_ctrl.v ***
// TAP controller with instruction scan, pause, exit2 and update handling
//
// Behaviour
// RL1: Pause-IR halts instruction shifting, stays while TMS low.
// RL2: Pause-IR with TMS high moves to Exit2-IR.
// RL3: Exit2-IR with TMS high moves to Update-IR.
// RL4: Exit2-IR with TMS low returns to Shift-IR.
// RL5: Pause and Exit2 keep instruction and selected data register.
// RL6: Update-IR copies shift path to instruction output on TCK fall.
// RL7: Latched instruction becomes current instruction for register select.
// RL8: Update-IR leaves selected data registers unchanged.
// RL9: Capture-IR loads pattern 100 into shift register on TCK rise.
// RL10: Shift-IR shifts TDI toward TDO each rising TCK.
// RL11: Exit1-IR with TMS low moves to Pause-IR.
// RL12: Five TMS-high edges reach reset; reset loads identification code.
// RL13: Update-IR goes to Select-DR if TMS high, else idle.
`include "tapir_regs.vh"
module tapir_ctrl #(
  parameter IR_WIDTH = `TAPIR_IR_WIDTH
) (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  output reg tdo_o,
  output reg tdo_oe_o,
  output reg [IR_WIDTH-1:0] insn_o,
  output reg [15:0] state_o,
  output reg dr_hold_o
);
  localparam [15:0] S_RESET = 16'h0001;
  localparam [15:0] S_IDLE = 16'h0002;
  localparam [15:0] S_SELDR = 16'h0004;
  localparam [15:0] S_CAPDR = 16'h0008;
  localparam [15:0] S_SHDR = 16'h0010;
  localparam [15:0] S_EX1DR = 16'h0020;
  localparam [15:0] S_PSDR = 16'h0040;
  localparam [15:0] S_EX2DR = 16'h0080;
  localparam [15:0] S_UPDR = 16'h0100;
  localparam [15:0] S_SELIR = 16'h0200;
  localparam [15:0] S_CAPIR = 16'h0400;
  localparam [15:0] S_SHIR = 16'h0800;
  localparam [15:0] S_EX1IR = 16'h1000;
  localparam [15:0] S_PSIR = 16'h2000;
  localparam [15:0] S_EX2IR = 16'h4000;
  localparam [15:0] S_UPIR = 16'h8000;

  wire tck_s;
  wire tms_s;
  wire tdi_s;
  reg tck_d;
  reg [15:0] state;
  reg [15:0] next_state;
  reg [IR_WIDTH-1:0] ir_shift;
  wire tck_rise;
  wire tck_fall;

  // Pins cross into the system clock before any logic reads them
  tapir_sync u_sync_tck (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .din_i(tck_i),
    .dout_o(tck_s)
  );
  tapir_sync u_sync_tms (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .din_i(tms_i),
    .dout_o(tms_s)
  );
  tapir_sync u_sync_tdi (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .din_i(tdi_i),
    .dout_o(tdi_s)
  );

  // TMS and TDI pass the same delay as TCK, so edges see aligned values
  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  always @* begin
    next_state = state;
    case (state)
      S_RESET: begin
        if (tms_s) begin
          next_state = S_RESET;
        end else begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (tms_s) begin
          next_state = S_SELDR;
        end else begin
          next_state = S_IDLE;
        end
      end
      S_SELDR: begin
        if (tms_s) begin
          next_state = S_SELIR;
        end else begin
          next_state = S_CAPDR;
        end
      end
      S_CAPDR: begin
        if (tms_s) begin
          next_state = S_EX1DR;
        end else begin
          next_state = S_SHDR;
        end
      end
      S_SHDR: begin
        if (tms_s) begin
          next_state = S_EX1DR;
        end else begin
          next_state = S_SHDR;
        end
      end
      S_EX1DR: begin
        if (tms_s) begin
          next_state = S_UPDR;
        end else begin
          next_state = S_PSDR;
        end
      end
      S_PSDR: begin
        if (tms_s) begin
          next_state = S_EX2DR;
        end else begin
          next_state = S_PSDR;
        end
      end
      S_EX2DR: begin
        if (tms_s) begin
          next_state = S_UPDR;
        end else begin
          next_state = S_SHDR;
        end
      end
      S_UPDR: begin
        if (tms_s) begin
          next_state = S_SELDR;
        end else begin
          next_state = S_IDLE;
        end
      end
      S_SELIR: begin
        if (tms_s) begin
          next_state = S_RESET;
        end else begin
          next_state = S_CAPIR;
        end
      end
      S_CAPIR: begin
        if (tms_s) begin
          next_state = S_EX1IR;
        end else begin
          next_state = S_SHIR;
        end
      end
      S_SHIR: begin
        if (tms_s) begin
          next_state = S_EX1IR;
        end else begin
          next_state = S_SHIR;
        end
      end
      S_EX1IR: begin
        if (tms_s) begin
          next_state = S_UPIR;
        end else begin
          next_state = S_PSIR; // [RL11]
        end
      end
      S_PSIR: begin
        if (tms_s) begin
          next_state = S_EX2IR; // [RL2]
        end else begin
          next_state = S_PSIR; // [RL1]
        end
      end
      S_EX2IR: begin
        if (tms_s) begin
          next_state = S_UPIR; // [RL3]
        end else begin
          next_state = S_SHIR; // [RL4]
        end
      end
      S_UPIR: begin
        if (tms_s) begin
          next_state = S_SELDR; // [RL13]
        end else begin
          next_state = S_IDLE; // [RL13]
        end
      end
      default: next_state = S_RESET;
    endcase
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tck_d <= 1'b0;
      state <= S_RESET;
      ir_shift <= `TAPIR_CAPTURE_PATTERN;
      insn_o <= `TAPIR_IDCODE_INSN;
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
      state_o <= S_RESET;
      dr_hold_o <= 1'b1;
    end else begin
      tck_d <= tck_s;
      if (tck_rise) begin
        // Every path from any state reaches reset in five TMS-high edges
        state <= next_state; // [RL12]
        state_o <= next_state;
        if (state == S_CAPIR) begin
          ir_shift <= `TAPIR_CAPTURE_PATTERN; // [RL9]
        end else if (state == S_SHIR) begin
          ir_shift <= {tdi_s, ir_shift[IR_WIDTH-1:1]}; // [RL10]
        end
        // Pause and exit2 fall through: shift path frozen [RL1] [RL5]
        if (next_state == S_RESET) begin
          insn_o <= `TAPIR_IDCODE_INSN; // [RL12]
        end
        // Data registers move only in their own DR states [RL5] [RL8]
        dr_hold_o <= ~((next_state == S_CAPDR) | (next_state == S_SHDR)
          | (next_state == S_UPDR));
      end
      if (tck_fall) begin
        // Driver changes on the fall, as a tester samples on the rise
        tdo_oe_o <= (state == S_SHIR) | (state == S_SHDR);
        tdo_o <= (state == S_SHIR) ? ir_shift[0] : 1'b0; // [RL10]
        if (state == S_UPIR) begin
          insn_o <= ir_shift; // [RL6] [RL7]
        end
      end
    end
  end
endmodule

// *** common/tapir_regs.vh ***
// Constants for the TAP instruction-register tail block
`ifndef TAPIR_REGS_VH
`define TAPIR_REGS_VH
`define TAPIR_IR_WIDTH 3
`define TAPIR_CAPTURE_PATTERN 3'h4
`define TAPIR_IDCODE_INSN 3'h1
`define TAPIR_RESET_TMS_EDGES 5
`define TAPIR_NUM_STATES 16
`endif

// *** rtl/tapir_sync.v ***
// Two-flip-flop synchroniser for pin inputs
module tapir_sync (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire din_i,
  output reg dout_o
);
  reg meta;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= 1'b0;
      dout_o <= 1'b0;
    end else begin
      meta <= din_i;
      dout_o <= meta;
    end
  end
endmodule

// *** verif/tapir_ctrl_monitor.sv ***
// Checker for the instruction tail of the TAP controller
module tapir_ctrl_monitor #(
  parameter IR_WIDTH = 3
) (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  input wire tdo_o,
  input wire tdo_oe_o,
  input wire [IR_WIDTH-1:0] insn_o,
  input wire [15:0] state_o,
  input wire dr_hold_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [15:0] ps;
  always @(posedge sys_clk_i) ps <= state_o;
  wire mv = state_o != ps;
  a_pause_exit: assert property (ps[13] && mv |-> state_o[14])
    else $error("pause exit");
  a_exit2_path: assert property (
    ps[14] && mv |-> state_o[15] | state_o[11])
    else $error("exit2 exit");
  a_exit1_path: assert property (
    ps[12] && mv |-> state_o[13] | state_o[15])
    else $error("exit1 exit");
  a_update_exit: assert property (
    ps[15] && mv |-> state_o[2] | state_o[1])
    else $error("update exit");
  a_shift_exit: assert property (ps[11] && mv |-> state_o[12])
    else $error("shift exit");
  a_insn_hold: assert property (!$stable(insn_o) |->
    $past(state_o[15]) || $past(state_o[0]) || state_o[0])
    else $error("insn moved");
  a_dr_hold: assert property ((|state_o[15:13]) && !mv |-> dr_hold_o)
    else $error("dr not held");
  a_pause_quiet: assert property (state_o[13] |-> !tdo_oe_o)
    else $error("tdo driven");
endmodule
bind tapir_ctrl tapir_ctrl_monitor #(.IR_WIDTH(IR_WIDTH)) u_mon (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .tck_i(tck_i), .tms_i(tms_i),
  .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .insn_o(insn_o),
  .state_o(state_o), .dr_hold_o(dr_hold_o));

// *** verif/tapir_tester.sv ***
// Model of the external scan tester
module tapir_tester (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Test clock idles low outside a step
  initial {tck_o, tms_o, tdi_o} = 3'h0;
  task step(input logic m, input logic d);
    tms_o = m;
    tdi_o = d;
    #62.5 tck_o = 1'b1;
    #62.5 tck_o = 1'b0;
  endtask
endmodule

// *** verif/tapir_ctrl_tb.sv ***
// Bench walking the instruction branch of the TAP controller
`include "tapir_regs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("Error %0t %h %h", $time, a, b); end end
module tapir_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [39:0] TM = 40'hecbb37d246;
  localparam logic [159:0] ST = 160'h09218543210921fcba921092fedcbbeddcbba921;
  logic sys_clk_i = 0, nrst_i = 0, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o;
  logic dr_hold_o;
  logic [2:0] insn_o, ir, e, li = `TAPIR_IDCODE_INSN, qi[$];
  logic [2:0] lw = `TAPIR_IDCODE_INSN, ei, et, qt[$];
  logic [15:0] state_o, ls = 16'h1, es, qs[$];
  logic [31:0] rs = 32'h43041e68;
  logic [3:0] ps = 4'h0, ns;
  int mismatches = 0, n_compared = 0;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  tapir_tester u_tst (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i));
  tapir_ctrl #(.IR_WIDTH(3)) DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o),
    .tdo_oe_o(tdo_oe_o), .insn_o(insn_o), .state_o(state_o),
    .dr_hold_o(dr_hold_o));
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial forever #4 sys_clk_i = ~sys_clk_i;
  initial begin
    #20us mismatches++;
    print_verdict;
  end
  always @(negedge sys_clk_i) if (nrst_i) begin
    if (state_o !== ls) begin
      ls = state_o;
      es = qs.size() ? qs.pop_front() : 16'hx;
      `CHK(state_o, es)
    end
    if (insn_o !== lw) begin
      lw = insn_o;
      ei = qi.size() ? qi.pop_front() : 3'hx;
      `CHK(insn_o, ei)
    end
  end
  // Serial outputs settle a few system cycles after each test clock fall
  always @(negedge tck_i) if (nrst_i) begin
    repeat (6) @(negedge sys_clk_i);
    et = qt.size() ? qt.pop_front() : 3'hx;
    `CHK({dr_hold_o, tdo_oe_o, tdo_o}, et)
  end
  initial begin
    repeat (12) @(negedge sys_clk_i);
    nrst_i = 1;
    for (int k = 0; k < 40; k++) begin
      @(negedge sys_clk_i);
      rs = xs(rs);
      ns = ST[4*k+:4];
      if (ps == 4'ha) ir = `TAPIR_CAPTURE_PATTERN;
      if (ps == 4'hb) ir = {rs[0], ir[2:1]};
      e = ns == 4'hf ? ir : ns == 4'h0 ? `TAPIR_IDCODE_INSN : li;
      if (ns != ps) qs.push_back(16'h1 << ns);
      if (e != li) qi.push_back(e);
      qt.push_back({ns != 4'h3 && ns != 4'h4 && ns != 4'h8,
        ns == 4'hb || ns == 4'h4, ns == 4'hb && ir[0]});
      li = e;
      u_tst.step(TM[k], rs[0]);
      ps = ns;
    end
    repeat (40) @(negedge sys_clk_i);
    `CHK(qs.size() + qi.size() + qt.size(), 0)
    $display("Instruction walk done");
    print_verdict;
  end
endmodule
